// file: test/macr_host.sv
`timescale 1ns/1ps
`default_nettype none
module macr_host (
   // Clock
   input wire logic clk,
   // Register bus
   output logic wr_en,
   output logic rd_en,
   output logic [15:0] addr,
   output logic [7:0] wdata,
   input wire logic [7:0] rdata
);
   initial
   begin
      wr_en = 1'b0;
      rd_en = 1'b0;
      addr = 16'h0000;
      wdata = 8'h00;
   end
   // Argument is twice the Celsius value
   function automatic logic [7:0] thr_code(input int half_deg);
      return 8'(half_deg + 82);
   endfunction
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk);
      #1;
      wr_en = 1'b1;
      addr = a;
      wdata = (a == 16'h0213) ? (d & 8'hFD) : d;
      @(posedge clk);
      #1;
      wr_en = 1'b0;
      // Released lines do not keep the last value
      addr = ~addr;
      wdata = ~wdata;
   endtask
   task automatic rd(input logic [15:0] a, output logic [7:0] d);
      @(posedge clk);
      #1;
      rd_en = 1'b1;
      addr = a;
      @(posedge clk);
      #1;
      rd_en = 1'b0;
      addr = ~addr;
      d = rdata;
   endtask
endmodule // macr_host
`default_nettype wire

// file: test/macr_sva.sv
`timescale 1ns/1ps
`default_nettype none
module macr_sva (
   // Clock and reset
   input wire logic I_MCLK,
   input wire logic I_RST,
   // Register access
   input wire logic I_WR_EN,
   input wire logic I_RD_EN,
   input wire logic [15:0] I_ADDR,
   input wire logic [7:0] I_WDATA,
   input wire logic [7:0] O_RDATA,
   // Mission and log
   input wire logic I_START_MISSION,
   input wire logic I_CONV_VALID,
   input wire logic [7:0] I_TEMP_RESULT_HIGH_BYTE,
   input wire logic O_OSCILLATOR_ENABLE,
   input wire logic O_STARTUP_BUSY,
   input wire logic O_CONV_WIDE,
   input wire logic O_MISSION_ACTIVE,
   input wire logic O_MEMORY_CLEARED,
   input wire logic O_HIGH_ALARM_FLAG,
   input wire logic O_LOW_ALARM_FLAG,
   input wire logic O_LOG_WE,
   input wire logic [16:0] O_LOG_ADDR,
   input wire logic [7:0] O_LOG_DATA
);
   // Shadow thresholds; they stay writable during a mission
   logic [7:0] hthr_r;
   logic [7:0] lthr_r;
   wire hi_hit = I_CONV_VALID && (I_TEMP_RESULT_HIGH_BYTE >= hthr_r);
   wire lo_hit = I_CONV_VALID && (I_TEMP_RESULT_HIGH_BYTE <= lthr_r);
   wire osc_wr = I_WR_EN && I_ADDR == 16'h0212 && !O_MISSION_ACTIVE && !I_START_MISSION;
   always_ff @(posedge I_MCLK)
      if (I_RST)
         hthr_r <= 8'h00;
      else if (I_WR_EN && I_ADDR == 16'h0209)
         hthr_r <= I_WDATA;
   always_ff @(posedge I_MCLK)
      if (I_RST)
         lthr_r <= 8'h00;
      else if (I_WR_EN && I_ADDR == 16'h0208)
         lthr_r <= I_WDATA;
   default clocking @(posedge I_MCLK);
   endclocking
   default disable iff (I_RST);
   sequence second_byte_s;
      O_LOG_WE && O_LOG_ADDR == $past(O_LOG_ADDR) + 17'h0_0001;
   endsequence
   start_forces_osc_a: assert property (I_START_MISSION && !O_MISSION_ACTIVE |=> O_OSCILLATOR_ENABLE)
      else $error("start left oscillator off");
   osc_write_a: assert property (osc_wr |=> O_OSCILLATOR_ENABLE == $past(I_WDATA[0]))
      else $error("oscillator enable not written");
   osc_locked_a: assert property (O_MISSION_ACTIVE && O_OSCILLATOR_ENABLE |=> O_OSCILLATOR_ENABLE)
      else $error("oscillator changed in mission");
   startup_delay_a: assert property (osc_wr && I_WDATA[0] && !O_OSCILLATOR_ENABLE && O_MEMORY_CLEARED
      |=> O_STARTUP_BUSY) else $error("no start-up delay");
   mission_ones_a: assert property (I_RD_EN && I_ADDR == 16'h0213 |=> O_RDATA[7:6] == 2'b11)
      else $error("mission control top bits not one");
   clock_zero_a: assert property (I_RD_EN && I_ADDR == 16'h0212 |=> O_RDATA[7:2] == 6'h00)
      else $error("clock control reserved bits set");
   sensor_zero_a: assert property (I_RD_EN && I_ADDR == 16'h0210 |=> O_RDATA[7:2] == 6'h00)
      else $error("sensor control reserved bits set");
   high_flag_a: assert property ($rose(O_HIGH_ALARM_FLAG) |-> $past(hi_hit))
      else $error("high flag without high reading");
   low_flag_a: assert property ($rose(O_LOW_ALARM_FLAG) |-> $past(lo_hit))
      else $error("low flag without low reading");
   wide_pair_a: assert property ($rose(O_LOG_WE) && O_CONV_WIDE |=> second_byte_s)
      else $error("wide sample not two bytes");
   narrow_single_a: assert property ($rose(O_LOG_WE) && !O_CONV_WIDE && !I_CONV_VALID |=> !O_LOG_WE)
      else $error("narrow sample wrote twice");
   log_msb_a: assert property ($rose(O_LOG_WE) |-> O_LOG_DATA == $past(I_TEMP_RESULT_HIGH_BYTE))
      else $error("first log byte not high byte");
endmodule // macr_sva
bind macr_top macr_sva u_sva (.I_MCLK(I_MCLK), .I_RST(I_RST), .I_WR_EN(I_WR_EN), .I_RD_EN(I_RD_EN),
   .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .O_RDATA(O_RDATA), .I_START_MISSION(I_START_MISSION),
   .I_CONV_VALID(I_CONV_VALID), .I_TEMP_RESULT_HIGH_BYTE(I_TEMP_RESULT_HIGH_BYTE),
   .O_OSCILLATOR_ENABLE(O_OSCILLATOR_ENABLE), .O_STARTUP_BUSY(O_STARTUP_BUSY), .O_CONV_WIDE(O_CONV_WIDE),
   .O_MISSION_ACTIVE(O_MISSION_ACTIVE), .O_MEMORY_CLEARED(O_MEMORY_CLEARED),
   .O_HIGH_ALARM_FLAG(O_HIGH_ALARM_FLAG), .O_LOW_ALARM_FLAG(O_LOW_ALARM_FLAG), .O_LOG_WE(O_LOG_WE),
   .O_LOG_ADDR(O_LOG_ADDR), .O_LOG_DATA(O_LOG_DATA));
`default_nettype wire

// file: test/macr_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module macr_top_tb;
   logic clk = 1'b0, rst = 1'b1, start_cmd = 1'b0, stop_cmd = 1'b0, clr_cmd = 1'b0, tick = 1'b0, cv = 1'b0;
   logic [7:0] hi = 8'h00, lo = 8'h00, rdata, th, tl, w, ldata, d;
   logic wr_en, rd_en, osc, busy, utick, wide, act, waitf, memclr, hflag, lflag, inc, lwe;
   logic eh = 1'b0, el = 1'b0, en_h = 1'b0, en_l = 1'b0;
   logic [15:0] addr;
   logic [16:0] laddr, ptr;
   int errors = 0, total_checks = 0, cycles = 0, n_ut = 0;
   logic [15:0] ra[7] = '{16'h0208, 16'h0209, 16'h0210, 16'h0212, 16'h0213, 16'h0214, 16'h0211};
   logic [7:0] re[7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hD0, 8'h70, 8'h00};
   logic [7:0] cvals[4] = '{8'h84, 8'h3F, 8'h85, 8'h3E};
   always #20 clk = ~clk;
   macr_host h (.clk(clk), .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wdata(w), .rdata(rdata));
   macr_top #(.STARTUP_CYCLES(8)) dut (.I_MCLK(clk), .I_RST(rst), .I_WR_EN(wr_en), .I_RD_EN(rd_en),
      .I_ADDR(addr), .I_WDATA(w), .O_RDATA(rdata), .I_START_MISSION(start_cmd), .I_STOP_MISSION(stop_cmd),
      .I_CLEAR_MEMORY(clr_cmd), .I_SECOND_TICK(tick), .I_CONV_VALID(cv), .I_TEMP_RESULT_HIGH_BYTE(hi),
      .I_TEMP_RESULT_LOW_BYTE(lo), .O_OSCILLATOR_ENABLE(osc), .O_STARTUP_BUSY(busy), .O_UNIT_TICK(utick),
      .O_CONV_WIDE(wide), .O_MISSION_ACTIVE(act), .O_WAIT_ALARM(waitf), .O_MEMORY_CLEARED(memclr),
      .O_HIGH_ALARM_FLAG(hflag), .O_LOW_ALARM_FLAG(lflag), .O_SAMPLE_CNT_INC(inc), .O_LOG_WE(lwe),
      .O_LOG_ADDR(laddr), .O_LOG_DATA(ldata));
   task automatic chk(input string nm, input logic [16:0] seen, input logic [16:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic conclude;
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         errors++;
         conclude;
      end
   end
   task automatic pulse(ref logic s);
      @(posedge clk);
      #1 s = 1'b1;
      @(posedge clk);
      #1 s = 1'b0;
   endtask
   task automatic rdchk(input logic [15:0] a, input logic [7:0] e);
      logic [7:0] v;
      h.rd(a, v);
      chk("rdata", v, e);
   endtask
   task automatic wait_idle;
      int n;
      n = 0;
      while (busy !== 1'b0 && n < 50)
      begin
         @(posedge clk);
         #1 n++;
      end
      chk("busy", busy, 1'b0);
   endtask
   // One conversion; checks the log writes and the sticky flags
   task automatic conv(input logic [7:0] t, input logic [7:0] l, input logic we_e, input logic cnt_e,
      input logic wide_e);
      @(posedge clk);
      #1 {cv, hi, lo} = {1'b1, t, l};
      @(posedge clk);
      #1 {cv, hi, lo} = {1'b0, ~t, ~l};
      eh = eh | (en_h && t >= th);
      el = el | (en_l && t <= tl);
      chk("high_flag", hflag, eh);
      chk("low_flag", lflag, el);
      chk("log_we", lwe, we_e);
      if (we_e)
      begin
         chk("log_addr", laddr, ptr);
         chk("log_hi", ldata, t);
         chk("cnt_inc", inc, cnt_e);
         ptr = ptr + 17'h0_0001;
      end
      if (wide_e)
      begin
         @(posedge clk);
         #1 chk("log_addr2", laddr, ptr);
         chk("log_lo", ldata, l & 8'hE0);
         ptr = ptr + 17'h0_0001;
      end
      @(posedge clk);
   endtask
   initial
   begin
      void'($urandom(58515));
      repeat (20) @(posedge clk);
      #1 rst = 1'b0;
      foreach (ra[i]) rdchk(ra[i], re[i]);
      repeat (4)
      begin
         d = 8'($urandom);
         h.wr(16'h0210, d);
         rdchk(16'h0210, d & 8'h03);
         h.wr(16'h0212, d);
         chk("osc", osc, d[0]);
         rdchk(16'h0212, d & 8'h03);
         h.wr(16'h0213, d);
         rdchk(16'h0213, (d & 8'hFD) | 8'hD0);
      end
      th = h.thr_code(51);
      tl = h.thr_code(-20);
      h.wr(16'h0209, th);
      h.wr(16'h0208, tl);
      rdchk(16'h0209, 8'h85);
      rdchk(16'h0208, 8'h3E);
      // Idle logger: oscillator off, then on from the cleared state
      pulse(clr_cmd);
      chk("memclr", memclr, 1'b1);
      h.wr(16'h0212, 8'h00);
      h.wr(16'h0212, 8'h03);
      chk("busy", busy, 1'b1);
      wait_idle();
      @(posedge clk);
      #1 tick = 1'b1;
      #1 chk("unit_tick", utick, 1'b1);
      h.wr(16'h0210, 8'h03);
      h.wr(16'h0213, 8'h05);
      tick = 1'b0;
      // Minutes unit: sixty seconds ticks give exactly one unit tick
      h.wr(16'h0212, 8'h01);
      repeat (60)
      begin
         @(posedge clk);
         #1 tick = 1'b1;
         #1 n_ut += (utick === 1'b1);
         @(posedge clk);
         #1 tick = 1'b0;
      end
      chk("minute_ticks", 17'(n_ut), 17'h0_0001);
      h.wr(16'h0212, 8'h03);
      {en_h, en_l, ptr} = {1'b1, 1'b1, 17'h0_1000};
      pulse(start_cmd);
      chk("osc", osc, 1'b1);
      chk("mission", act, 1'b1);
      chk("memclr", memclr, 1'b0);
      h.wr(16'h0212, 8'h00);
      rdchk(16'h0212, 8'h03);
      h.wr(16'h0213, 8'h00);
      rdchk(16'h0213, 8'hD5);
      wait_idle();
      foreach (cvals[i]) conv(cvals[i], 8'($urandom), 1'b1, 1'b1, 1'b1);
      repeat (4) conv(8'($urandom), 8'($urandom), 1'b1, 1'b1, 1'b1);
      pulse(stop_cmd);
      chk("mission", act, 1'b0);
      pulse(clr_cmd);
      chk("high_flag", hflag, 1'b0);
      chk("low_flag", lflag, 1'b0);
      // Start on alarm, single-byte log, high alarm only
      {eh, el, en_l, ptr} = {1'b0, 1'b0, 1'b0, 17'h0_1000};
      h.wr(16'h0210, 8'h02);
      h.wr(16'h0213, 8'h21);
      pulse(start_cmd);
      wait_idle();
      chk("wait", waitf, 1'b1);
      chk("wide", wide, 1'b0);
      conv(8'h10, 8'h00, 1'b0, 1'b0, 1'b0);
      conv(8'h40, 8'h00, 1'b0, 1'b0, 1'b0);
      conv(8'h90, 8'h00, 1'b1, 1'b0, 1'b0);
      chk("wait", waitf, 1'b0);
      conv(8'h50, 8'h00, 1'b1, 1'b1, 1'b0);
      conclude;
   end
endmodule // macr_top_tb
`default_nettype wire

// file: verilog/macr_regs.vh
`ifndef MACR_REGS_VH
`define MACR_REGS_VH
// Register addresses
`define MACR_ADDR_W 16
`define MACR_LOW_THR_ADDR 16'h0208
`define MACR_HIGH_THR_ADDR 16'h0209
`define MACR_SENSOR_CTL_ADDR 16'h0210
`define MACR_CLOCK_CTL_ADDR 16'h0212
`define MACR_MISSION_CTL_ADDR 16'h0213
`define MACR_ALARM_STAT_ADDR 16'h0214
// Field positions
`define MACR_LOW_EN_BIT 0
`define MACR_HIGH_EN_BIT 1
`define MACR_OSC_EN_BIT 0
`define MACR_UNIT_SEC_BIT 1
`define MACR_LOG_EN_BIT 0
`define MACR_HOST_B1_BIT 1
`define MACR_FORMAT_BIT 2
`define MACR_HOST_B3_BIT 3
`define MACR_START_ON_ALARM_BIT 5
`define MACR_LOW_FLAG_BIT 0
`define MACR_HIGH_FLAG_BIT 1
// Fixed read patterns
`define MACR_ZERO_BYTE 8'h00
`define MACR_MISSION_ONES 8'hD0
`define MACR_ALARM_ONES 8'h70
`define MACR_LOW_VALID_MASK 8'hE0
// Reset values
`define MACR_THR_RESET 8'h00
`define MACR_CTL_RESET 1'b0
// Data-log memory
`define MACR_LOG_AW 17
`define MACR_LOG_BASE 17'h0_1000
`define MACR_LOG_STEP1 17'h0_0001
`define MACR_LOG_STEP2 17'h0_0002
// Timing
`define MACR_CLK_MHZ 25
`define MACR_CLOCK_STARTUP_DELAY_US 1000
`define MACR_STARTUP_W 20
`define MACR_SEC_PER_MIN 6'h3C
`define MACR_MIN_CNT_ONE 6'h01
`define MACR_MIN_CNT_ZERO 6'h00
`define MACR_STARTUP_ONE 20'h0_0001
`define MACR_STARTUP_ZERO 20'h0_0000
`endif

// file: verilog/macr_top.v
// How it works
// - Codes are high byte/2 - 41, plus masked low byte/512 in wide format.
// - Thresholds are single bytes, low at 0208h, high at 0209h.
// - Alarm compares use only the conversion high byte, any width.
// - An alarm is raised only if value alarms and its enable is set.
// - Sensor control bits 7:2 read zero and ignore written ones.
// - High enable bit 1 set: high byte at or above high threshold sets flag.
// - Low enable bit 0 set: high byte at or below low threshold sets flag.
// - Clock control bit 0 starts the oscillator; zero stops it.
// - Mission start command forces the oscillator enable to one.
// - Enabling the oscillator while memory is cleared adds a start-up delay.
// - Clock control bit 1 picks minutes (0) or seconds (1) sample unit.
// - Clock control bits 7:2 always read zero and take no ones.
// - During a mission the three control registers ignore writes.
// - Mission control bits 7:6 always read one.
// - Start-on-alarm bit 5: 8-bit conversions until an alarm starts logging.
// - The alarming reading is logged first without advancing the sample counter.
// - Format bit 2 logs one byte when zero, two bytes when one.
// - Two-byte logging puts the high byte at the lower address.
// - Logging needs enable bit 0; log data starts at 1000h.
// - Clear memory clears both alarm flags together.
`timescale 1ns/1ps
`include "macr_regs.vh"
`default_nettype none
module macr_top #(
   parameter STARTUP_CYCLES = `MACR_CLOCK_STARTUP_DELAY_US * `MACR_CLK_MHZ
)
(
   // Clock and reset
   input wire I_MCLK,
   input wire I_RST,
   // Register access
   input wire I_WR_EN,
   input wire I_RD_EN,
   input wire [`MACR_ADDR_W-1:0] I_ADDR,
   input wire [7:0] I_WDATA,
   output reg [7:0] O_RDATA,
   // Mission commands
   input wire I_START_MISSION,
   input wire I_STOP_MISSION,
   input wire I_CLEAR_MEMORY,
   // Time base and conversions
   input wire I_SECOND_TICK,
   input wire I_CONV_VALID,
   input wire [7:0] I_TEMP_RESULT_HIGH_BYTE,
   input wire [7:0] I_TEMP_RESULT_LOW_BYTE,
   // Status and control outputs
   output wire O_OSCILLATOR_ENABLE,
   output wire O_STARTUP_BUSY,
   output wire O_UNIT_TICK,
   output wire O_CONV_WIDE,
   output wire O_MISSION_ACTIVE,
   output wire O_WAIT_ALARM,
   output wire O_MEMORY_CLEARED,
   output wire O_HIGH_ALARM_FLAG,
   output wire O_LOW_ALARM_FLAG,
   output reg O_SAMPLE_CNT_INC,
   // Data-log write port
   output reg O_LOG_WE,
   output reg [`MACR_LOG_AW-1:0] O_LOG_ADDR,
   output reg [7:0] O_LOG_DATA
);
   localparam [1:0] ST_IDLE = 2'b01;
   localparam [1:0] ST_LOW = 2'b10;
   localparam [`MACR_STARTUP_W-1:0] STARTUP_LOAD = STARTUP_CYCLES[`MACR_STARTUP_W-1:0];

   reg [7:0] low_thr_r;
   reg [7:0] high_thr_r;
   reg low_alarm_enable_r;
   reg high_alarm_enable_r;
   reg oscillator_enable_r;
   reg sample_unit_seconds_r;
   reg logging_enable_r;
   reg log_format_select_r;
   reg start_on_alarm_r;
   reg host_b1_r;
   reg host_b3_r;
   reg mission_r;
   reg wait_alarm_r;
   reg memclr_r;
   reg high_alarm_flag_r;
   reg low_alarm_flag_r;
   reg [`MACR_STARTUP_W-1:0] startup_r;
   reg [5:0] min_cnt_r;
   reg [1:0] state_r;
   reg [1:0] state_nxt;
   reg [`MACR_LOG_AW-1:0] log_ptr_r;
   reg [7:0] low_byte_r;
   wire ctl_wr_ok;
   wire running;
   wire hi_hit;
   wire lo_hit;
   wire hi_alarm;
   wire lo_alarm;
   wire sample_ev;
   wire log_ev;
   wire osc_rise;

   // Control registers refuse writes while a mission runs
   assign ctl_wr_ok = I_WR_EN & ~mission_r;
   // Alarm compares only after the start-up delay has expired
   assign running = mission_r & (startup_r == `MACR_STARTUP_ZERO);
   assign hi_hit = I_TEMP_RESULT_HIGH_BYTE >= high_thr_r;
   assign lo_hit = I_TEMP_RESULT_HIGH_BYTE <= low_thr_r;
   assign hi_alarm = hi_hit & high_alarm_enable_r;
   assign lo_alarm = lo_hit & low_alarm_enable_r;
   assign sample_ev = I_CONV_VALID & running;
   // A conversion arriving mid two-byte write is dropped; samples are at least a second apart
   assign log_ev = sample_ev & logging_enable_r & (state_r == ST_IDLE) &
      (~wait_alarm_r | hi_alarm | lo_alarm);
   assign osc_rise = ~oscillator_enable_r &
      ((ctl_wr_ok & (I_ADDR == `MACR_CLOCK_CTL_ADDR) & I_WDATA[`MACR_OSC_EN_BIT]) |
      (I_START_MISSION & ~mission_r));

   assign O_OSCILLATOR_ENABLE = oscillator_enable_r;
   assign O_STARTUP_BUSY = (startup_r != `MACR_STARTUP_ZERO);
   assign O_CONV_WIDE = log_format_select_r & ~wait_alarm_r;
   assign O_MISSION_ACTIVE = mission_r;
   assign O_WAIT_ALARM = wait_alarm_r;
   assign O_MEMORY_CLEARED = memclr_r;
   assign O_HIGH_ALARM_FLAG = high_alarm_flag_r;
   assign O_LOW_ALARM_FLAG = low_alarm_flag_r;
   // Minutes unit divides the seconds tick by sixty
   assign O_UNIT_TICK = I_SECOND_TICK & oscillator_enable_r &
      (sample_unit_seconds_r | (min_cnt_r == `MACR_MIN_CNT_ZERO));

   // Threshold and control registers
   always @(posedge I_MCLK)
   begin
      if (I_RST)
      begin
         low_thr_r <= `MACR_THR_RESET;
         high_thr_r <= `MACR_THR_RESET;
         low_alarm_enable_r <= `MACR_CTL_RESET;
         high_alarm_enable_r <= `MACR_CTL_RESET;
         oscillator_enable_r <= `MACR_CTL_RESET;
         sample_unit_seconds_r <= `MACR_CTL_RESET;
         logging_enable_r <= `MACR_CTL_RESET;
         log_format_select_r <= `MACR_CTL_RESET;
         start_on_alarm_r <= `MACR_CTL_RESET;
         host_b1_r <= `MACR_CTL_RESET;
         host_b3_r <= `MACR_CTL_RESET;
      end
      else
      begin
         if (I_WR_EN && I_ADDR == `MACR_LOW_THR_ADDR)
         begin
            low_thr_r <= I_WDATA;
         end
         if (I_WR_EN && I_ADDR == `MACR_HIGH_THR_ADDR)
         begin
            high_thr_r <= I_WDATA;
         end
         // Upper bits are never stored, so they read back as zero
         if (ctl_wr_ok && I_ADDR == `MACR_SENSOR_CTL_ADDR)
         begin
            low_alarm_enable_r <= I_WDATA[`MACR_LOW_EN_BIT];
            high_alarm_enable_r <= I_WDATA[`MACR_HIGH_EN_BIT];
         end
         if (I_START_MISSION && !mission_r)
         begin
            oscillator_enable_r <= 1'b1;
         end
         else if (ctl_wr_ok && I_ADDR == `MACR_CLOCK_CTL_ADDR)
         begin
            oscillator_enable_r <= I_WDATA[`MACR_OSC_EN_BIT];
         end
         if (ctl_wr_ok && I_ADDR == `MACR_CLOCK_CTL_ADDR)
         begin
            sample_unit_seconds_r <= I_WDATA[`MACR_UNIT_SEC_BIT];
         end
         if (ctl_wr_ok && I_ADDR == `MACR_MISSION_CTL_ADDR)
         begin
            logging_enable_r <= I_WDATA[`MACR_LOG_EN_BIT];
            host_b1_r <= I_WDATA[`MACR_HOST_B1_BIT];
            log_format_select_r <= I_WDATA[`MACR_FORMAT_BIT];
            host_b3_r <= I_WDATA[`MACR_HOST_B3_BIT];
            start_on_alarm_r <= I_WDATA[`MACR_START_ON_ALARM_BIT];
         end
      end
   end

   // Mission state, memory-cleared state and alarm flags
   always @(posedge I_MCLK)
   begin
      if (I_RST)
      begin
         mission_r <= 1'b0;
         wait_alarm_r <= 1'b0;
         memclr_r <= 1'b0;
         high_alarm_flag_r <= 1'b0;
         low_alarm_flag_r <= 1'b0;
      end
      else
      begin
         if (I_START_MISSION && !mission_r)
         begin
            mission_r <= 1'b1;
            wait_alarm_r <= start_on_alarm_r;
            memclr_r <= 1'b0;
         end
         else if (I_STOP_MISSION)
         begin
            mission_r <= 1'b0;
         end
         else if (I_CLEAR_MEMORY && !mission_r)
         begin
            memclr_r <= 1'b1;
         end
         if (sample_ev && wait_alarm_r && (hi_alarm || lo_alarm))
         begin
            wait_alarm_r <= 1'b0;
         end
         // A flag set in the same cycle as a clear wins
         if (sample_ev && hi_alarm)
         begin
            high_alarm_flag_r <= 1'b1;
         end
         else if (I_CLEAR_MEMORY && !mission_r)
         begin
            high_alarm_flag_r <= 1'b0;
         end
         if (sample_ev && lo_alarm)
         begin
            low_alarm_flag_r <= 1'b1;
         end
         else if (I_CLEAR_MEMORY && !mission_r)
         begin
            low_alarm_flag_r <= 1'b0;
         end
      end
   end

   // Start-up delay and minute prescaler
   always @(posedge I_MCLK)
   begin
      if (I_RST)
      begin
         startup_r <= `MACR_STARTUP_ZERO;
         min_cnt_r <= `MACR_MIN_CNT_ZERO;
      end
      else
      begin
         if (osc_rise && memclr_r)
         begin
            startup_r <= STARTUP_LOAD;
         end
         else if (!oscillator_enable_r)
         begin
            startup_r <= `MACR_STARTUP_ZERO;
         end
         else if (startup_r != `MACR_STARTUP_ZERO)
         begin
            startup_r <= startup_r - `MACR_STARTUP_ONE;
         end
         if (I_SECOND_TICK && oscillator_enable_r)
         begin
            if (min_cnt_r == `MACR_SEC_PER_MIN - `MACR_MIN_CNT_ONE)
            begin
               min_cnt_r <= `MACR_MIN_CNT_ZERO;
            end
            else
            begin
               min_cnt_r <= min_cnt_r + `MACR_MIN_CNT_ONE;
            end
         end
      end
   end

   // Data-log writer
   always @*
   begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE:
         begin
            if (log_ev && log_format_select_r)
            begin
               state_nxt = ST_LOW;
            end
         end
         ST_LOW:
         begin
            state_nxt = ST_IDLE;
         end
         default:
         begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   always @(posedge I_MCLK)
   begin
      if (I_RST)
      begin
         state_r <= ST_IDLE;
         log_ptr_r <= `MACR_LOG_BASE;
         low_byte_r <= `MACR_ZERO_BYTE;
         O_LOG_WE <= 1'b0;
         O_LOG_ADDR <= `MACR_LOG_BASE;
         O_LOG_DATA <= `MACR_ZERO_BYTE;
         O_SAMPLE_CNT_INC <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         O_LOG_WE <= 1'b0;
         O_SAMPLE_CNT_INC <= 1'b0;
         if (I_START_MISSION && !mission_r)
         begin
            log_ptr_r <= `MACR_LOG_BASE;
         end
         else if (state_r == ST_LOW)
         begin
            O_LOG_WE <= 1'b1;
            O_LOG_ADDR <= log_ptr_r + `MACR_LOG_STEP1;
            O_LOG_DATA <= low_byte_r;
            log_ptr_r <= log_ptr_r + `MACR_LOG_STEP2;
         end
         else if (log_ev)
         begin
            O_LOG_WE <= 1'b1;
            O_LOG_ADDR <= log_ptr_r;
            O_LOG_DATA <= I_TEMP_RESULT_HIGH_BYTE;
            // Only the three top bits of the low byte carry resolution
            low_byte_r <= wait_alarm_r ? `MACR_ZERO_BYTE :
               (I_TEMP_RESULT_LOW_BYTE & `MACR_LOW_VALID_MASK);
            O_SAMPLE_CNT_INC <= ~wait_alarm_r;
            if (!log_format_select_r)
            begin
               log_ptr_r <= log_ptr_r + `MACR_LOG_STEP1;
            end
         end
      end
   end

   // Register read port
   always @(posedge I_MCLK)
   begin
      if (I_RST)
      begin
         O_RDATA <= `MACR_ZERO_BYTE;
      end
      else if (I_RD_EN)
      begin
         case (I_ADDR)
            `MACR_LOW_THR_ADDR: O_RDATA <= low_thr_r;
            `MACR_HIGH_THR_ADDR: O_RDATA <= high_thr_r;
            `MACR_SENSOR_CTL_ADDR: O_RDATA <= {6'h00, high_alarm_enable_r, low_alarm_enable_r};
            `MACR_CLOCK_CTL_ADDR: O_RDATA <= {6'h00, sample_unit_seconds_r, oscillator_enable_r};
            `MACR_MISSION_CTL_ADDR: O_RDATA <= `MACR_MISSION_ONES | {2'b00, start_on_alarm_r, 1'b0,
               host_b3_r, log_format_select_r, host_b1_r, logging_enable_r};
            `MACR_ALARM_STAT_ADDR: O_RDATA <= `MACR_ALARM_ONES |
               {6'h00, high_alarm_flag_r, low_alarm_flag_r};
            default: O_RDATA <= `MACR_ZERO_BYTE;
         endcase
      end
   end
endmodule // macr_top
`default_nettype wire
